// file: inc/lte_event_pkg.sv
// types shared by the timer event flag block
// assumes: lte_event_regs.svh is on the include path
`include "lte_event_regs.svh"

package lte_event_pkg;

	typedef logic [`LTE_NUM_FLAGS-1:0] lte_flags_type;

	// peripheral bus request, one access per setup/access pair
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} lte_bus_req_type;

	// single-cycle events and levels from the counter core, same clock
	typedef struct packed {
		logic enc_mode;
		logic count_down;
		logic arr_wr_done;
		logic cmp_wr_done;
		logic trig_edge;
		logic timer_started;
	} lte_core_evt_type;

	typedef struct packed {
		lte_flags_type flags;
		lte_flags_type ien;
		logic dir_down;
		logic arr_eq;
		logic cmp_eq;
		logic irq;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
	} lte_state_type;

endpackage

// file: inc/lte_event_regs.svh
// register offsets, field positions, reset values of the timer event flags
// assumes: included by bare name from the event flag package and module
// Summary of operation
// - encoder up-to-down reversal sets flag bit 6
// - encoder down-to-up reversal sets flag bit 5
// - autoreload write completion sets flag bit 4
// - compare write completion sets flag bit 3
// - valid selected trigger edge sets flag bit 2
// - trigger ignored while running leaves flag alone
// - counter reaching autoreload sets flag bit 1
// - counter reaching compare sets flag bit 0
// - enable bit per flag gates its interrupt
`ifndef LTE_EVENT_REGS_SVH
`define LTE_EVENT_REGS_SVH

`define LTE_OFS_STATUS 12'h000
`define LTE_OFS_ENABLE 12'h008

`define LTE_NUM_FLAGS 7
`define LTE_BIT_DIR_DOWN 6
`define LTE_BIT_DIR_UP 5
`define LTE_BIT_ARR_DONE 4
`define LTE_BIT_CMP_DONE 3
`define LTE_BIT_TRIG 2
`define LTE_BIT_ARR_MATCH 1
`define LTE_BIT_CMP_MATCH 0

`define LTE_RST_STATUS 7'h00
`define LTE_RST_ENABLE 7'h00

`endif

// file: testbench/lte_event_flags_tb.sv
// self-checking bench for the timer event flags and interrupt enables
// assumes: zero-wait register bus, core events are one-cycle pulses
`timescale 1ns/100ps

module lte_event_flags_tb;

logic clk_i = 1'b0;
logic sys_rst_i = 1'b1;
lte_event_pkg::lte_bus_req_type b = '0;
lte_event_pkg::lte_core_evt_type c = '0;
lte_event_pkg::lte_flags_type clr = '0;
logic [15:0] cnt = 16'h0000;
logic [15:0] arr = 16'h0005;
logic [15:0] cmp = 16'h0009;
logic [6:0] en = 7'h00;
logic [31:0] prdata_o;
logic pready_o;
logic pslverr_o;
lte_event_pkg::lte_flags_type event_status_o;
lte_event_pkg::lte_flags_type event_enable_o;
logic irq_o;
int fail_count = 0;
int checks = 0;

lte_event_flags #(.CNT_W(16)) u_lte_event_flags (
	.clk_i(clk_i),
	.sys_rst_i(sys_rst_i),
	.bus_i(b),
	.core_i(c),
	.counter_value_i(cnt),
	.autoreload_i(arr),
	.compare_value_i(cmp),
	.flag_clear_i(clr),
	.prdata_o(prdata_o),
	.pready_o(pready_o),
	.pslverr_o(pslverr_o),
	.event_status_o(event_status_o),
	.event_enable_o(event_enable_o),
	.irq_o(irq_o)
);

always #10 clk_i = ~clk_i;

////////////////////////////////////////////////////////////////////////
task end_sim;
	if (fail_count == 0 && checks > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask

task chk(input logic [31:0] g, input logic [31:0] x);
	checks++;
	if (g !== x) begin
		fail_count++;
		$display("unexpected at %0t: got %h want %h", $time, g, x);
	end
endtask

// zero wait states, so ready missing in the access cycle is a mismatch
task acc(input logic w, input logic [11:0] a, input logic [31:0] d,
	output logic [31:0] r, output logic e);
	@(posedge clk_i);
	#1 b = '{1'b1, 1'b0, w, a, d};
	@(posedge clk_i);
	#1 b.enable = 1'b1;
	#17 if (pready_o !== 1'b1) begin
		fail_count++;
		$display("unexpected at %0t: no ready", $time);
	end
	r = prdata_o;
	e = pslverr_o;
	@(posedge clk_i);
	#1 b = '0;
endtask

task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
	logic [31:0] r;
	logic e;
	acc(1'b0, a, 32'h00000000, r, e);
	chk(r, x);
	chk(e, xe);
endtask

task wr(input logic [11:0] a, input logic [31:0] d);
	logic [31:0] r;
	logic e;
	acc(1'b1, a, d, r, e);
endtask

// level fields of the core word are kept, pulses dropped after one cycle
task ev(input logic [5:0] v, input logic [6:0] x);
	@(posedge clk_i);
	#1 c = v;
	@(posedge clk_i);
	#1 c = v & 6'h31;
	chk(event_status_o, x);
	chk(irq_o, |(x & en));
	clr = '1;
	@(posedge clk_i);
	#1 clr = '0;
	chk(event_status_o, 7'h00);
endtask

////////////////////////////////////////////////////////////////////////
task t_regs;
	rd(12'h000, 32'h00000000, 1'b0);
	rd(12'h008, 32'h00000000, 1'b0);
	wr(12'h008, 32'h0000007F);
	en = 7'h7F;
	rd(12'h008, 32'h0000007F, 1'b0);
	chk(event_enable_o, en);
	wr(12'h000, 32'h0000007F);
	rd(12'h000, 32'h00000000, 1'b0);
	rd(12'h004, 32'h00000000, 1'b1);
endtask

task t_events;
	ev(6'h08, 7'h10);
	ev(6'h04, 7'h08);
	ev(6'h02, 7'h04);
	ev(6'h03, 7'h00);
	ev(6'h30, 7'h40);
	ev(6'h20, 7'h20);
	ev(6'h10, 7'h00);
	ev(6'h00, 7'h00);
endtask

// a match held for several cycles must flag only once
task t_match;
	@(posedge clk_i);
	#1 cnt = 16'h0005;
	@(posedge clk_i);
	#1 chk(event_status_o, 7'h02);
	clr = '1;
	@(posedge clk_i);
	#1 clr = '0;
	@(posedge clk_i);
	#1 chk(event_status_o, 7'h00);
	cnt = 16'h0009;
	@(posedge clk_i);
	#1 chk(event_status_o, 7'h01);
	chk(irq_o, 1'b1);
	clr = '1;
	@(posedge clk_i);
	#1 clr = '0;
endtask

task t_mask;
	wr(12'h008, 32'h00000010);
	en = 7'h10;
	ev(6'h04, 7'h08);
	ev(6'h08, 7'h10);
endtask

////////////////////////////////////////////////////////////////////////
initial begin
	repeat (3) @(posedge clk_i);
	#1 sys_rst_i = 1'b0;
	t_regs();
	t_events();
	t_match();
	t_mask();
	end_sim();
end

endmodule

// file: verilog/lte_event_flags.sv
// event status flags, interrupt enables and interrupt request of the timer
// assumes: core events come from logic on clk_i; bus is APB-style, no waits
`timescale 1ns/100ps
`include "lte_event_regs.svh"

module lte_event_flags #(
	parameter int CNT_W = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire lte_event_pkg::lte_bus_req_type bus_i,
	input wire lte_event_pkg::lte_core_evt_type core_i,
	input wire logic [CNT_W-1:0] counter_value_i,
	input wire logic [CNT_W-1:0] autoreload_i,
	input wire logic [CNT_W-1:0] compare_value_i,
	input wire lte_event_pkg::lte_flags_type flag_clear_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output lte_event_pkg::lte_flags_type event_status_o,
	output lte_event_pkg::lte_flags_type event_enable_o,
	output logic irq_o
);

	lte_event_pkg::lte_state_type st_q;
	lte_event_pkg::lte_state_type st_d;

	function automatic logic is_offset(input logic [11:0] a,
		input logic [11:0] ofs);
		is_offset = (a[11:2] == ofs[11:2]);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state

	logic setup_ph;
	logic wr_acc;
	logic arr_eq_now;
	logic cmp_eq_now;
	lte_event_pkg::lte_flags_type set_vec;

	always_comb begin
		setup_ph = bus_i.sel & ~bus_i.enable;
		wr_acc = bus_i.sel & bus_i.enable & bus_i.write & st_q.ready;
		arr_eq_now = (counter_value_i == autoreload_i);
		cmp_eq_now = (compare_value_i == counter_value_i);
		set_vec = '0;
		// direction is only meaningful while decoding an encoder
		set_vec[`LTE_BIT_DIR_DOWN] = core_i.enc_mode & core_i.count_down
			& ~st_q.dir_down;
		set_vec[`LTE_BIT_DIR_UP] = core_i.enc_mode & ~core_i.count_down
			& st_q.dir_down;
		set_vec[`LTE_BIT_ARR_DONE] = core_i.arr_wr_done;
		set_vec[`LTE_BIT_CMP_DONE] = core_i.cmp_wr_done;
		// an edge that arrives after start is dropped, not reported
		set_vec[`LTE_BIT_TRIG] = core_i.trig_edge
			& ~core_i.timer_started;
		// flag on the cycle equality appears, not while it persists
		set_vec[`LTE_BIT_ARR_MATCH] = arr_eq_now & ~st_q.arr_eq;
		set_vec[`LTE_BIT_CMP_MATCH] = cmp_eq_now & ~st_q.cmp_eq;

		st_d = st_q;
		st_d.dir_down = core_i.count_down;
		st_d.arr_eq = arr_eq_now;
		st_d.cmp_eq = cmp_eq_now;
		// sticky; a set in the clearing cycle wins over the clear
		st_d.flags = (st_q.flags & ~flag_clear_i) | set_vec;

		// reserved bits of the write are simply not stored
		if (wr_acc && is_offset(bus_i.addr, `LTE_OFS_ENABLE)) begin
			st_d.ien = bus_i.wdata[`LTE_NUM_FLAGS-1:0];
		end
		st_d.irq = |(st_d.flags & st_d.ien);

		// answer prepared in setup so the access phase needs no wait
		st_d.ready = setup_ph;
		st_d.slverr = 1'b0;
		st_d.rdata = 32'h00000000;
		if (setup_ph) begin
			if (is_offset(bus_i.addr, `LTE_OFS_STATUS)) begin
				if (!bus_i.write) begin
					st_d.rdata = {25'h0000000, st_q.flags};
				end
			end else if (is_offset(bus_i.addr, `LTE_OFS_ENABLE)) begin
				if (!bus_i.write) begin
					st_d.rdata = {25'h0000000, st_q.ien};
				end
			end else begin
				st_d.slverr = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_q.flags <= `LTE_RST_STATUS;
			st_q.ien <= `LTE_RST_ENABLE;
			st_q.dir_down <= 1'b0;
			st_q.arr_eq <= 1'b0;
			st_q.cmp_eq <= 1'b0;
			st_q.irq <= 1'b0;
			st_q.rdata <= 32'h00000000;
			st_q.ready <= 1'b0;
			st_q.slverr <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	always_comb begin
		prdata_o = st_q.rdata;
		pready_o = st_q.ready;
		pslverr_o = st_q.slverr;
		event_status_o = st_q.flags;
		event_enable_o = st_q.ien;
		irq_o = st_q.irq;
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_rev_down;
		core_i.enc_mode && core_i.count_down && !st_q.dir_down;
	endsequence

	sequence s_rev_up;
		core_i.enc_mode && !core_i.count_down && st_q.dir_down;
	endsequence

	sequence s_valid_trig;
		core_i.trig_edge && !core_i.timer_started;
	endsequence

	a_dir_down_set: assert property (
		s_rev_down |=> event_status_o[`LTE_BIT_DIR_DOWN])
		else $error("down reversal did not set its flag");

	a_dir_up_set: assert property (
		s_rev_up |=> event_status_o[`LTE_BIT_DIR_UP])
		else $error("up reversal did not set its flag");

	a_arr_done_set: assert property (
		core_i.arr_wr_done |=> event_status_o[`LTE_BIT_ARR_DONE])
		else $error("autoreload write done not flagged");

	a_cmp_done_set: assert property (
		core_i.cmp_wr_done |=> event_status_o[`LTE_BIT_CMP_DONE])
		else $error("compare write done not flagged");

	a_trig_flag_set: assert property (
		s_valid_trig |=> event_status_o[`LTE_BIT_TRIG])
		else $error("valid trigger edge not flagged");

	a_trig_ignored_kept: assert property (
		!event_status_o[`LTE_BIT_TRIG]
		&& !(core_i.trig_edge && !core_i.timer_started)
		|=> !event_status_o[`LTE_BIT_TRIG])
		else $error("trigger flag set without a valid edge");

	a_arr_match_set: assert property (
		$rose(counter_value_i == autoreload_i) && $past(!sys_rst_i)
		|=> event_status_o[`LTE_BIT_ARR_MATCH])
		else $error("autoreload match not flagged");

	// a match that persists must not be reported again after a clear
	a_arr_match_held: assert property (
		(counter_value_i == autoreload_i) && $past(!sys_rst_i)
		&& $past(counter_value_i == autoreload_i)
		&& !event_status_o[`LTE_BIT_ARR_MATCH]
		|=> !event_status_o[`LTE_BIT_ARR_MATCH])
		else $error("held autoreload match flagged again");

	a_dir_needs_enc: assert property (
		!core_i.enc_mode
		&& event_status_o[`LTE_BIT_DIR_DOWN:`LTE_BIT_DIR_UP] == 2'b00
		|=> event_status_o[`LTE_BIT_DIR_DOWN:`LTE_BIT_DIR_UP] == 2'b00)
		else $error("direction flag set outside encoder mode");

	a_cmp_match_set: assert property (
		$rose(counter_value_i == compare_value_i) && $past(!sys_rst_i)
		|=> event_status_o[`LTE_BIT_CMP_MATCH])
		else $error("compare match not flagged");

	a_irq_gating: assert property (
		irq_o == |(event_status_o & event_enable_o))
		else $error("interrupt does not follow enabled flags");

	a_flag_sticky: assert property (
		1'b1 |=> (($past(event_status_o) & ~$past(flag_clear_i)
		& ~event_status_o) == 7'h00))
		else $error("flag dropped without a clear");

	a_bus_answer: assert property (
		bus_i.sel && !bus_i.enable |=> pready_o ##1 !pready_o)
		else $error("bus answer not a single cycle");

	sequence s_setup;
		bus_i.sel && !bus_i.enable;
	endsequence

	a_ready_only_setup: assert property (
		!(bus_i.sel && !bus_i.enable) |=> !pready_o)
		else $error("ready without a setup phase");

	a_status_read: assert property (
		s_setup ##0 (!bus_i.write
		&& is_offset(bus_i.addr, `LTE_OFS_STATUS))
		|=> prdata_o == {25'h0000000, $past(event_status_o)})
		else $error("status read returned wrong data");

	a_enable_read: assert property (
		s_setup ##0 (!bus_i.write
		&& is_offset(bus_i.addr, `LTE_OFS_ENABLE))
		|=> prdata_o == {25'h0000000, $past(event_enable_o)})
		else $error("enable read returned wrong data");

	a_bad_addr_err: assert property (
		s_setup ##0 (!is_offset(bus_i.addr, `LTE_OFS_STATUS)
		&& !is_offset(bus_i.addr, `LTE_OFS_ENABLE))
		|=> pslverr_o && prdata_o == 32'h00000000)
		else $error("unmapped access not refused");

	a_enable_write: assert property (
		bus_i.sel && bus_i.enable && bus_i.write && pready_o
		&& is_offset(bus_i.addr, `LTE_OFS_ENABLE)
		|=> event_enable_o == $past(bus_i.wdata[`LTE_NUM_FLAGS-1:0]))
		else $error("enable write not stored");

	a_enable_kept: assert property (
		!(bus_i.sel && bus_i.enable && bus_i.write && pready_o
		&& is_offset(bus_i.addr, `LTE_OFS_ENABLE))
		|=> $stable(event_enable_o))
		else $error("enable register changed without a write");

endmodule
